// >>> common/wdrl_defs.vh
// constants for the watchdog time-out and reload lock block
// How it works
// [RULE1] a reset-mode time-out outside stop mode pulses the system reset and sets the watchdog cause flag.
// [RULE2] a reset-mode time-out in stop mode starts stop-mode recovery instead of a system reset.
// [RULE3] after a stop-mode time-out both the watchdog cause flag and the stop recovery flag read 1.
// [RULE4] reload bytes stay protected until 55H then AAH are written back to back to the control address.
// [RULE5] unlock writes to the control address leave the control register bits unchanged.
// [RULE6] software writes the upper, then high, then low reload byte after unlocking.
// [RULE7] software makes no other register write between the steps of the sequence.
// [RULE8] any other write during the sequence relocks and rejects reload writes until a fresh 55H.
// [RULE9] the reload value is copied into the counter on first enable and on every refresh.
// [RULE10] software should load factory calibration to correct the imprecise oscillator period.
// [RULE11] an interrupt-mode time-out in stop mode recovers and then raises the interrupt if enabled.
// [RULE12] in debug mode an enabled watchdog is refreshed continuously and never times out.
// [RULE13] the counter decrements each tick from the 24-bit reload and times out at zero.
`ifndef WDRL_DEFS_VH
`define WDRL_DEFS_VH
// ****************
// register offsets
// ****************
`define WDRL_CTRL_OFF 8'h00
`define WDRL_RLDU_OFF 8'h04
`define WDRL_RLDH_OFF 8'h08
`define WDRL_RLDL_OFF 8'h0C
`define WDRL_CAUSE_OFF 8'h10
`define WDRL_IRQ_STAT_OFF 8'h14
`define WDRL_IRQ_CLR_OFF 8'h18
`define WDRL_IRQ_EN_OFF 8'h1C
`define WDRL_COUNT_OFF 8'h20
// ****************
// fields and values
// ****************
`define WDRL_CTRL_EN_BIT 0
`define WDRL_CTRL_INTMODE_BIT 1
`define WDRL_CAUSE_WDT_BIT 0
`define WDRL_CAUSE_STOP_BIT 1
`define WDRL_UNLOCK1 8'h55
`define WDRL_UNLOCK2 8'hAA
`define WDRL_RLD_RESET 24'hFFFFFF
`define WDRL_RESP_OKAY 2'b00
`define WDRL_RESP_SLVERR 2'b10
`endif

// >>> design/wdrl_top.v
// watchdog time-out handling with reload lock, AXI4-Lite slave
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "wdrl_defs.vh"
module wdrl_top #(
  parameter RLD_W = 24
) (
  mclk,
  rst_n,
  ce,
  s_axi_awaddr,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_araddr,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready,
  wdt_tick,
  refresh,
  stop_mode,
  debug_mode,
  irq_global_en,
  sys_reset,
  stop_recover,
  wdt_irq,
  irq
);
  input wire mclk;
  input wire rst_n;
  input wire ce;
  input wire [7:0] s_axi_awaddr;
  input wire s_axi_awvalid;
  output reg s_axi_awready;
  input wire [31:0] s_axi_wdata;
  input wire [3:0] s_axi_wstrb;
  input wire s_axi_wvalid;
  output reg s_axi_wready;
  output reg [1:0] s_axi_bresp;
  output reg s_axi_bvalid;
  input wire s_axi_bready;
  input wire [7:0] s_axi_araddr;
  input wire s_axi_arvalid;
  output reg s_axi_arready;
  output reg [31:0] s_axi_rdata;
  output reg [1:0] s_axi_rresp;
  output reg s_axi_rvalid;
  input wire s_axi_rready;
  input wire wdt_tick;
  input wire refresh;
  input wire stop_mode;
  input wire debug_mode;
  input wire irq_global_en;
  output reg sys_reset;
  output reg stop_recover;
  output reg wdt_irq;
  output reg irq;

  // ****************
  // lock states
  // ****************
  localparam [2:0] LK_LOCKED = 3'd0;
  localparam [2:0] LK_GOT55 = 3'd1;
  localparam [2:0] LK_OPEN_U = 3'd2;
  localparam [2:0] LK_OPEN_H = 3'd3;
  localparam [2:0] LK_OPEN_L = 3'd4;

  function is_mapped;
    input [7:0] a;
    begin
      if (a == `WDRL_CTRL_OFF) is_mapped = 1'b1;
      else if (a == `WDRL_RLDU_OFF) is_mapped = 1'b1;
      else if (a == `WDRL_RLDH_OFF) is_mapped = 1'b1;
      else if (a == `WDRL_RLDL_OFF) is_mapped = 1'b1;
      else if (a == `WDRL_CAUSE_OFF) is_mapped = 1'b1;
      else if (a == `WDRL_IRQ_STAT_OFF) is_mapped = 1'b1;
      else if (a == `WDRL_IRQ_CLR_OFF) is_mapped = 1'b1;
      else if (a == `WDRL_IRQ_EN_OFF) is_mapped = 1'b1;
      else if (a == `WDRL_COUNT_OFF) is_mapped = 1'b1;
      else is_mapped = 1'b0;
    end
  endfunction

  reg [7:0] awaddr_q;
  reg aw_have_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_have_q;
  reg [1:0] ctrl_q;
  reg [RLD_W-1:0] rld_q;
  reg [RLD_W-1:0] cnt_q;
  reg run_q;
  reg [2:0] lk_q;
  reg [2:0] lk_d;
  reg [1:0] cause_q;
  reg [1:0] stat_q;
  reg [1:0] ien_q;
  reg irq_pend_q;

  wire wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire [7:0] wb = wdata_q[7:0];
  wire wb_ok = wstrb_q[0];
  wire wr_ctrl = wr_go & (awaddr_q == `WDRL_CTRL_OFF);
  wire is_55 = wr_ctrl & wb_ok & (wb == `WDRL_UNLOCK1);
  wire is_aa = wr_ctrl & wb_ok & (wb == `WDRL_UNLOCK2);
  wire wr_u = wr_go & (awaddr_q == `WDRL_RLDU_OFF) & (lk_q == LK_OPEN_U);
  wire wr_h = wr_go & (awaddr_q == `WDRL_RLDH_OFF) & (lk_q == LK_OPEN_H);
  wire wr_l = wr_go & (awaddr_q == `WDRL_RLDL_OFF) & (lk_q == LK_OPEN_L);
  wire en_now = ctrl_q[`WDRL_CTRL_EN_BIT];
  wire int_mode = ctrl_q[`WDRL_CTRL_INTMODE_BIT];
  wire load = (en_now & ~run_q) | (en_now & refresh) | (en_now & debug_mode); // RULE9 RULE12
  wire timeout = en_now & run_q & ~load & wdt_tick & (cnt_q == {RLD_W{1'b0}}); // RULE13
  wire clr_hit = wr_go & (awaddr_q == `WDRL_IRQ_CLR_OFF) & wb_ok;
  wire [1:0] ev = {timeout & stop_mode, timeout};

  // ****************
  // lock state machine
  // ****************
  always @* begin
    lk_d = lk_q;
    if (wr_go) begin
      case (lk_q)
        LK_LOCKED: lk_d = is_55 ? LK_GOT55 : LK_LOCKED; // RULE4
        LK_GOT55: lk_d = is_aa ? LK_OPEN_U : (is_55 ? LK_GOT55 : LK_LOCKED); // RULE4 RULE8
        LK_OPEN_U: lk_d = wr_u ? LK_OPEN_H : (is_55 ? LK_GOT55 : LK_LOCKED); // RULE8
        LK_OPEN_H: lk_d = wr_h ? LK_OPEN_L : (is_55 ? LK_GOT55 : LK_LOCKED); // RULE8
        LK_OPEN_L: lk_d = is_55 ? LK_GOT55 : LK_LOCKED; // RULE8
        default: lk_d = LK_LOCKED;
      endcase
    end
  end

  // ****************
  // bus slave and registers
  // ****************
  always @(posedge mclk) begin
    if (!rst_n) begin
      awaddr_q <= 8'h00;
      aw_have_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      w_have_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `WDRL_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `WDRL_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      ctrl_q <= 2'b00;
      rld_q <= `WDRL_RLD_RESET;
      lk_q <= LK_LOCKED;
      ien_q <= 2'b00;
    end else if (ce) begin
      s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      lk_q <= lk_d;
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(awaddr_q) ? `WDRL_RESP_OKAY : `WDRL_RESP_SLVERR;
        // unlock bytes never reach the control bits
        if (wr_ctrl & wb_ok & ~is_55 & ~is_aa) ctrl_q <= wb[1:0]; // RULE5
        if (wr_u) rld_q[23:16] <= wb; // RULE6
        if (wr_h) rld_q[15:8] <= wb; // RULE6
        if (wr_l) rld_q[7:0] <= wb; // RULE6
        if ((awaddr_q == `WDRL_IRQ_EN_OFF) & wb_ok) ien_q <= wb[1:0];
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= is_mapped(s_axi_araddr) ? `WDRL_RESP_OKAY : `WDRL_RESP_SLVERR;
        if (s_axi_araddr == `WDRL_CTRL_OFF) s_axi_rdata <= {30'd0, ctrl_q};
        else if (s_axi_araddr == `WDRL_RLDU_OFF) s_axi_rdata <= {24'd0, rld_q[23:16]};
        else if (s_axi_araddr == `WDRL_RLDH_OFF) s_axi_rdata <= {24'd0, rld_q[15:8]};
        else if (s_axi_araddr == `WDRL_RLDL_OFF) s_axi_rdata <= {24'd0, rld_q[7:0]};
        else if (s_axi_araddr == `WDRL_CAUSE_OFF) s_axi_rdata <= {30'd0, cause_q};
        else if (s_axi_araddr == `WDRL_IRQ_STAT_OFF) s_axi_rdata <= {30'd0, stat_q};
        else if (s_axi_araddr == `WDRL_IRQ_EN_OFF) s_axi_rdata <= {30'd0, ien_q};
        else if (s_axi_araddr == `WDRL_COUNT_OFF) s_axi_rdata <= {{(32-RLD_W){1'b0}}, cnt_q};
        else s_axi_rdata <= 32'h00000000;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************
  // counter and time-out actions
  // ****************
  always @(posedge mclk) begin
    if (!rst_n) begin
      cnt_q <= `WDRL_RLD_RESET;
      run_q <= 1'b0;
      sys_reset <= 1'b0;
      stop_recover <= 1'b0;
      irq_pend_q <= 1'b0;
      wdt_irq <= 1'b0;
      stat_q <= 2'b00;
      irq <= 1'b0;
    end else if (ce) begin
      run_q <= en_now;
      if (load) cnt_q <= rld_q; // RULE9 RULE12
      else if (en_now & wdt_tick & (cnt_q != {RLD_W{1'b0}})) cnt_q <= cnt_q - 1'b1; // RULE13
      else if (timeout) cnt_q <= rld_q;
      // one-cycle pulses towards the reset and clock controller
      sys_reset <= timeout & ~int_mode & ~stop_mode; // RULE1
      stop_recover <= timeout & stop_mode; // RULE2 RULE11
      // the interrupt waits for the recovery pulse to go first
      irq_pend_q <= timeout & int_mode;
      wdt_irq <= irq_pend_q & irq_global_en; // RULE11
      // set wins over a clear in the same cycle
      stat_q <= (stat_q & ~(clr_hit ? wb[1:0] : 2'b00)) | ev;
      irq <= |((stat_q | ev) & ien_q);
    end
  end

  // cause flags survive the system reset they report, so they use no reset here
  always @(posedge mclk) begin
    if (ce & timeout) begin
      cause_q[`WDRL_CAUSE_WDT_BIT] <= 1'b1; // RULE1 RULE3
      cause_q[`WDRL_CAUSE_STOP_BIT] <= stop_mode; // RULE3
    end else if (ce & wr_go & (awaddr_q == `WDRL_CAUSE_OFF) & wb_ok) begin
      cause_q <= cause_q & ~wb[1:0];
    end
  end
endmodule

// >>> sim/wdrl_asserts.sv
// port checks for the watchdog reload lock block
`timescale 1ns/1ps
module wdrl_asserts (
  input wire mclk,
  input wire rst_n,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire stop_mode,
  input wire debug_mode,
  input wire irq_global_en,
  input wire sys_reset,
  input wire stop_recover,
  input wire wdt_irq
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence b_wait; s_axi_bvalid && !s_axi_bready; endsequence
  sequence r_wait; s_axi_rvalid && !s_axi_rready; endsequence
  // three cycles so a pulse launched just before entry has drained
  sequence in_debug; debug_mode [*3]; endsequence
  b_hold_a: assert property (b_wait |=> s_axi_bvalid) else $error("bvalid dropped");
  r_hold_a: assert property (r_wait |=> s_axi_rvalid) else $error("rvalid dropped");
  rst_pulse_a: assert property (sys_reset |=> !sys_reset) else $error("reset pulse long");
  rst_run_a: assert property (sys_reset |-> !$past(stop_mode)) else $error("reset in stop");
  recov_stop_a: assert property (stop_recover |-> $past(stop_mode))
    else $error("recovery outside stop");
  one_action_a: assert property (!(sys_reset && stop_recover)) else $error("both actions");
  debug_quiet_a: assert property (in_debug |-> !sys_reset && !stop_recover)
    else $error("timeout in debug");
  irq_gate_a: assert property (wdt_irq |-> $past(irq_global_en))
    else $error("irq while disabled");
endmodule
bind wdrl_top wdrl_asserts u_chk (.mclk(mclk), .rst_n(rst_n), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .stop_mode(stop_mode), .debug_mode(debug_mode), .irq_global_en(irq_global_en),
  .sys_reset(sys_reset), .stop_recover(stop_recover), .wdt_irq(wdt_irq));

// >>> sim/tb.sv
// self-checking bench for the watchdog reload lock block
`timescale 1ns/1ps
`include "wdrl_defs.vh"
module tb;
  logic mclk, rst_n, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, wdt_tick, refresh, stop_mode, debug_mode, irq_global_en;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire sys_reset, stop_recover, wdt_irq, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int num_errors = 0, cmp_count = 0, cyc = 0;
  wdrl_top dut (.mclk, .rst_n, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .wdt_tick, .refresh, .stop_mode, .debug_mode,
    .irq_global_en, .sys_reset, .stop_recover, .wdt_irq, .irq);
  // ****************
  // tasks
  // ****************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw && w)) begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
    end
    while (!s_axi_bvalid) @(posedge mclk);
    chk(s_axi_bresp, er);
    s_axi_bready <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'b00);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge mclk); while (!s_axi_rvalid);
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, er);
    s_axi_rready <= 0;
  endtask
  // sel 0 system reset, 1 stop recovery, 2 watchdog interrupt
  task wt(input int sel);
    do @(posedge mclk); while (!(sel == 0 ? sys_reset : sel == 1 ? stop_recover : wdt_irq));
  endtask
  task wrap_up;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    mclk = 0;
    forever #12.5 mclk = ~mclk;
  end
  // whole sequence needs well under 2000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    {wdt_tick, refresh, stop_mode, debug_mode, irq_global_en, s_axi_awaddr} = 0;
    {s_axi_araddr, s_axi_wdata} = 0;
    ce = 1;
    s_axi_wstrb = 4'hF;
    repeat (5) @(posedge mclk);
    rst_n <= 1;
    rd(`WDRL_CTRL_OFF, 32'h0);
    wr(`WDRL_RLDU_OFF, 32'h0);
    rd(`WDRL_RLDU_OFF, 32'hFF);
    wr(`WDRL_CTRL_OFF, 32'h55);
    wr(`WDRL_CTRL_OFF, 32'hAA);
    rd(`WDRL_CTRL_OFF, 32'h0);
    wr(`WDRL_RLDU_OFF, 32'h0);
    wr(`WDRL_RLDH_OFF, 32'h0);
    wr(`WDRL_RLDL_OFF, 32'h5);
    rd(`WDRL_RLDL_OFF, 32'h5);
    wr(`WDRL_CTRL_OFF, 32'h55);
    wr(`WDRL_IRQ_EN_OFF, 32'h1);
    wr(`WDRL_CTRL_OFF, 32'hAA);
    wr(`WDRL_RLDU_OFF, 32'h7);
    rd(`WDRL_RLDU_OFF, 32'h0);
    wr(`WDRL_CTRL_OFF, 32'h1);
    rd(`WDRL_COUNT_OFF, 32'h5);
    wdt_tick <= 1;
    wt(0);
    wdt_tick <= 0;
    rd(`WDRL_CAUSE_OFF, 32'h1);
    rd(`WDRL_IRQ_STAT_OFF, 32'h1);
    chk(irq, 1);
    wr(`WDRL_IRQ_EN_OFF, 32'h0);
    @(posedge mclk);
    chk(irq, 0);
    wr(`WDRL_IRQ_EN_OFF, 32'h1);
    wr(`WDRL_IRQ_CLR_OFF, 32'h3);
    @(posedge mclk);
    chk(irq, 0);
    wr(`WDRL_CAUSE_OFF, 32'h3);
    stop_mode <= 1;
    wdt_tick <= 1;
    wt(1);
    wdt_tick <= 0;
    stop_mode <= 0;
    rd(`WDRL_CAUSE_OFF, 32'h3);
    wr(`WDRL_CTRL_OFF, 32'h3);
    irq_global_en <= 1;
    stop_mode <= 1;
    wdt_tick <= 1;
    wt(1);
    wt(2);
    stop_mode <= 0;
    debug_mode <= 1;
    repeat (40) @(posedge mclk);
    rd(`WDRL_COUNT_OFF, 32'h5);
    debug_mode <= 0;
    repeat (2) @(posedge mclk);
    wdt_tick <= 0;
    refresh <= 1;
    @(posedge mclk);
    refresh <= 0;
    rd(`WDRL_COUNT_OFF, 32'h5);
    wr(8'h3C, 32'h1, `WDRL_RESP_SLVERR);
    rd(8'h3C, 32'h0, `WDRL_RESP_SLVERR);
    wrap_up();
  end
endmodule
